// ===== design/crm_pkg.sv
// Purpose: Constants and types shared by the register model with RAM
// Assumes: 50 MHz system clock, plain register port with 16-bit data
// Notes: Register indices are word addresses on the register port
package crm_pkg;
   // Register port map
   localparam logic [3:0] REG_PC = 4'h0;
   localparam logic [3:0] REG_SP = 4'h1;
   localparam logic [3:0] REG_IX = 4'h2;
   localparam logic [3:0] REG_ACCA = 4'h3;
   localparam logic [3:0] REG_ACCB = 4'h4;
   localparam logic [3:0] REG_CCR = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam logic [3:0] REG_ALU_OP = 4'h7;
   // Flag register fields
   localparam int CCR_C = 0;
   localparam int CCR_V = 1;
   localparam int CCR_Z = 2;
   localparam int CCR_N = 3;
   localparam int CCR_I = 4;
   localparam int CCR_H = 5;
   localparam logic [7:0] CCR_FIXED_ONES = 8'hc0;
   localparam logic [7:0] CCR_RESET = 8'hd0;
   // Status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_NMI_PEND = 1;
   localparam int ST_STANDBY = 2;
   localparam int ST_RAM_EN = 3;
   // ALU operation codes
   localparam logic [1:0] ALU_ADD = 2'h0;
   localparam logic [1:0] ALU_SUB = 2'h1;
   localparam logic [1:0] ALU_AND = 2'h2;
   localparam logic [1:0] ALU_OR = 2'h3;
   // Internal RAM
   localparam int RAM_BYTES = 128;
   localparam logic [15:0] RAM_LAST = 16'h007f;
   localparam logic [15:0] RAM_KEEP_LAST = 16'h001f;
   // Vectors, high byte first
   localparam logic [15:0] VEC_IRQ = 16'hfff8;
   localparam logic [15:0] VEC_NMI = 16'hfffc;
   localparam logic [15:0] VEC_RESTART = 16'hfffe;
   // Machine cycle is four oscillator periods
   localparam logic [1:0] DIV_LAST = 2'h3;
   localparam logic [2:0] PUSH_LAST = 3'h6;
   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_PUSH,
      SEQ_VEC_HI,
      SEQ_VEC_LO
   } crm_seq_t;
endpackage : crm_pkg

// ===== design/crm_top.sv
// Purpose: Programmer register set and 128-byte internal RAM of an 8-bit processor
// Assumes: All inputs synchronous to i_clk; external memory answers reads within the read pulse
// Notes: Register port data is 16 bits, 8-bit registers sit in the low byte
`timescale 1ns/10ps
`default_nettype none
module crm_top (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   // Parallel bus access to internal RAM
   input wire logic [15:0] i_bus_addr,
   input wire logic [7:0] i_bus_wdata,
   input wire logic i_bus_wr,
   input wire logic i_bus_rd,
   output logic [7:0] o_bus_rdata,
   output logic o_bus_data_oe,
   output logic o_ram_hit,
   // RAM gating and standby
   input wire logic i_ram_enable,
   input wire logic i_standby,
   // Interrupt requests and program step
   input wire logic i_irq_req,
   input wire logic i_nmi_req,
   input wire logic i_pc_step,
   // External memory master for stack and vectors
   output logic [15:0] o_ext_addr,
   output logic [7:0] o_ext_wdata,
   output logic o_ext_wr,
   output logic o_ext_rd,
   input wire logic [7:0] i_ext_rdata,
   // Machine cycle enable
   output logic o_mcycle_en
);
   typedef struct packed {
      logic [1:0] div;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] ix;
      logic [7:0] acca;
      logic [7:0] accb;
      logic [7:0] ccr;
      logic [crm_pkg::RAM_BYTES-1:0][7:0] ram;
      logic [15:0] reg_rdata;
      logic [7:0] bus_rdata;
      logic bus_oe;
      logic ram_hit;
      logic nmi_prev;
      logic nmi_pend;
      crm_pkg::crm_seq_t seq;
      logic [2:0] cnt;
      logic rd_wait;
      logic [15:0] vec;
      logic [15:0] ext_addr;
      logic [7:0] ext_wdata;
      logic ext_wr;
      logic ext_rd;
   } crm_state_t;

   crm_state_t s_reg;
   crm_state_t s_next;
   logic mcycle;
   logic ram_sel;
   logic [6:0] ram_idx;
   logic [8:0] alu_sum;
   logic [7:0] alu_res;
   logic [7:0] push_byte;

   assign mcycle = (s_reg.div == crm_pkg::DIV_LAST);
   // RAM decoded only while enabled and awake
   assign ram_sel = i_ram_enable && !i_standby
                    && (i_bus_addr <= crm_pkg::RAM_LAST);
   assign ram_idx = i_bus_addr[6:0];

   always_comb begin
      alu_sum = 9'h000;
      alu_res = 8'h00;
      case (i_reg_wdata[1:0])
         crm_pkg::ALU_ADD: begin
            alu_sum = {1'b0, s_reg.acca} + {1'b0, s_reg.accb};
            alu_res = alu_sum[7:0];
         end
         crm_pkg::ALU_SUB: begin
            alu_sum = {1'b0, s_reg.acca} - {1'b0, s_reg.accb};
            alu_res = alu_sum[7:0];
         end
         crm_pkg::ALU_AND: alu_res = s_reg.acca & s_reg.accb;
         default: alu_res = s_reg.acca | s_reg.accb;
      endcase
   end

   always_comb begin
      case (s_reg.cnt)
         3'h0: push_byte = s_reg.pc[7:0];
         3'h1: push_byte = s_reg.pc[15:8];
         3'h2: push_byte = s_reg.ix[7:0];
         3'h3: push_byte = s_reg.ix[15:8];
         3'h4: push_byte = s_reg.acca;
         3'h5: push_byte = s_reg.accb;
         default: push_byte = s_reg.ccr;
      endcase
   end

   always_comb begin
      logic a7;
      logic b7;
      logic r7;
      logic a3;
      logic b3;
      logic r3;
      a7 = s_reg.acca[7];
      b7 = s_reg.accb[7];
      r7 = alu_res[7];
      a3 = s_reg.acca[3];
      b3 = s_reg.accb[3];
      r3 = alu_res[3];
      s_next = s_reg;
      s_next.div = s_reg.div + 2'h1;
      s_next.ext_wr = 1'b0;
      s_next.ext_rd = 1'b0;
      s_next.bus_oe = 1'b0;
      s_next.ram_hit = 1'b0;
      s_next.reg_rdata = 16'h0000;
      s_next.nmi_prev = i_nmi_req;

      // Upper bytes are not retained in standby
      if (i_standby) begin
         for (int k = int'(crm_pkg::RAM_KEEP_LAST) + 1; k < crm_pkg::RAM_BYTES; k++) begin
            s_next.ram[k] = 8'h00;
         end
      end

      // Internal RAM on the parallel bus
      if (ram_sel && i_bus_wr) begin
         s_next.ram[ram_idx] = i_bus_wdata;
         s_next.ram_hit = 1'b1;
      end else if (ram_sel && i_bus_rd) begin
         s_next.bus_rdata = s_reg.ram[ram_idx];
         s_next.bus_oe = 1'b1;
         s_next.ram_hit = 1'b1;
      end

      // Register port reads, answer next cycle
      if (i_reg_rd) begin
         if (i_reg_addr == crm_pkg::REG_PC) begin
            s_next.reg_rdata = s_reg.pc;
         end else if (i_reg_addr == crm_pkg::REG_SP) begin
            s_next.reg_rdata = s_reg.sp;
         end else if (i_reg_addr == crm_pkg::REG_IX) begin
            s_next.reg_rdata = s_reg.ix;
         end else if (i_reg_addr == crm_pkg::REG_ACCA) begin
            s_next.reg_rdata = {8'h00, s_reg.acca};
         end else if (i_reg_addr == crm_pkg::REG_ACCB) begin
            s_next.reg_rdata = {8'h00, s_reg.accb};
         end else if (i_reg_addr == crm_pkg::REG_CCR) begin
            s_next.reg_rdata = {8'h00, s_reg.ccr | crm_pkg::CCR_FIXED_ONES};
         end else if (i_reg_addr == crm_pkg::REG_STATUS) begin
            s_next.reg_rdata[crm_pkg::ST_BUSY] = (s_reg.seq != crm_pkg::SEQ_IDLE);
            s_next.reg_rdata[crm_pkg::ST_NMI_PEND] = s_reg.nmi_pend;
            s_next.reg_rdata[crm_pkg::ST_STANDBY] = i_standby;
            s_next.reg_rdata[crm_pkg::ST_RAM_EN] = i_ram_enable;
         end
      end

      // Register port writes, only while no sequence runs
      if (i_reg_wr && s_reg.seq == crm_pkg::SEQ_IDLE) begin
         if (i_reg_addr == crm_pkg::REG_PC) begin
            s_next.pc = i_reg_wdata;
         end else if (i_reg_addr == crm_pkg::REG_SP) begin
            s_next.sp = i_reg_wdata;
         end else if (i_reg_addr == crm_pkg::REG_IX) begin
            s_next.ix = i_reg_wdata;
         end else if (i_reg_addr == crm_pkg::REG_ACCA) begin
            s_next.acca = i_reg_wdata[7:0];
         end else if (i_reg_addr == crm_pkg::REG_ACCB) begin
            s_next.accb = i_reg_wdata[7:0];
         end else if (i_reg_addr == crm_pkg::REG_CCR) begin
            s_next.ccr = i_reg_wdata[7:0] | crm_pkg::CCR_FIXED_ONES;
         end else if (i_reg_addr == crm_pkg::REG_ALU_OP) begin
            s_next.acca = alu_res;
            s_next.ccr[crm_pkg::CCR_N] = r7;
            s_next.ccr[crm_pkg::CCR_Z] = (alu_res == 8'h00);
            case (i_reg_wdata[1:0])
               crm_pkg::ALU_ADD: begin
                  s_next.ccr[crm_pkg::CCR_C] = alu_sum[8];
                  s_next.ccr[crm_pkg::CCR_V] = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
                  s_next.ccr[crm_pkg::CCR_H] = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
               end
               crm_pkg::ALU_SUB: begin
                  s_next.ccr[crm_pkg::CCR_C] = alu_sum[8];
                  s_next.ccr[crm_pkg::CCR_V] = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
               end
               default: s_next.ccr[crm_pkg::CCR_V] = 1'b0;
            endcase
         end
      end else if (i_pc_step && s_reg.seq == crm_pkg::SEQ_IDLE) begin
         s_next.pc = s_reg.pc + 16'h0001;
      end

      // Interrupt and restart sequencer, one step per machine cycle
      case (s_reg.seq)
         crm_pkg::SEQ_IDLE: begin
            if (mcycle && s_reg.nmi_pend) begin
               s_next.seq = crm_pkg::SEQ_PUSH;
               s_next.vec = crm_pkg::VEC_NMI;
               s_next.cnt = 3'h0;
            end else if (mcycle && i_irq_req && !s_reg.ccr[crm_pkg::CCR_I]) begin
               s_next.seq = crm_pkg::SEQ_PUSH;
               s_next.vec = crm_pkg::VEC_IRQ;
               s_next.cnt = 3'h0;
            end
         end
         crm_pkg::SEQ_PUSH: begin
            if (mcycle) begin
               s_next.ext_addr = s_reg.sp;
               s_next.ext_wdata = push_byte;
               s_next.ext_wr = 1'b1;
               s_next.sp = s_reg.sp - 16'h0001;
               s_next.cnt = s_reg.cnt + 3'h1;
               if (s_reg.cnt == crm_pkg::PUSH_LAST) begin
                  s_next.ccr[crm_pkg::CCR_I] = 1'b1;
                  s_next.seq = crm_pkg::SEQ_VEC_HI;
               end
            end
         end
         crm_pkg::SEQ_VEC_HI: begin
            if (s_reg.rd_wait) begin
               s_next.rd_wait = 1'b0;
               s_next.pc[15:8] = i_ext_rdata;
               s_next.seq = crm_pkg::SEQ_VEC_LO;
            end else if (mcycle) begin
               s_next.ext_addr = s_reg.vec;
               s_next.ext_rd = 1'b1;
               s_next.rd_wait = 1'b1;
            end
         end
         default: begin
            if (s_reg.rd_wait) begin
               s_next.rd_wait = 1'b0;
               s_next.pc[7:0] = i_ext_rdata;
               s_next.seq = crm_pkg::SEQ_IDLE;
            end else if (mcycle) begin
               s_next.ext_addr = s_reg.vec + 16'h0001;
               s_next.ext_rd = 1'b1;
               s_next.rd_wait = 1'b1;
            end
         end
      endcase

      // Edge capture of the non-maskable request; a new edge beats the clear
      if (s_reg.seq == crm_pkg::SEQ_IDLE && s_next.seq == crm_pkg::SEQ_PUSH
          && s_reg.nmi_pend) begin
         s_next.nmi_pend = 1'b0;
      end
      if (i_nmi_req && !s_reg.nmi_prev) begin
         s_next.nmi_pend = 1'b1;
      end

      if (i_srst) begin
         s_next = '0;
         s_next.ram = s_reg.ram;
         s_next.ccr = crm_pkg::CCR_RESET;
         s_next.vec = crm_pkg::VEC_RESTART;
         s_next.seq = crm_pkg::SEQ_VEC_HI;
      end
   end

   always_ff @(posedge i_clk) begin
      s_reg <= s_next;
   end

   assign o_reg_rdata = s_reg.reg_rdata;
   assign o_bus_rdata = s_reg.bus_rdata;
   assign o_bus_data_oe = s_reg.bus_oe;
   assign o_ram_hit = s_reg.ram_hit;
   assign o_ext_addr = s_reg.ext_addr;
   assign o_ext_wdata = s_reg.ext_wdata;
   assign o_ext_wr = s_reg.ext_wr;
   assign o_ext_rd = s_reg.ext_rd;
   assign o_mcycle_en = mcycle;
endmodule : crm_top
`default_nettype wire

// ===== dv/crm_checker.sv
// Purpose: Port assertions for crm_top
// Assumes: One clock, sync reset
// Notes: Bound at foot of file
`timescale 1ns/10ps
`default_nettype none
module crm_checker (
   // Clock and register port
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] o_reg_rdata,
   // RAM bus
   input wire logic [15:0] i_bus_addr,
   input wire logic [7:0] i_bus_wdata,
   input wire logic i_bus_wr,
   input wire logic i_bus_rd,
   input wire logic [7:0] o_bus_rdata,
   input wire logic o_bus_data_oe,
   input wire logic o_ram_hit,
   input wire logic i_ram_enable,
   input wire logic i_standby,
   // Requests and external master
   input wire logic i_irq_req,
   input wire logic i_nmi_req,
   input wire logic i_pc_step,
   input wire logic [15:0] o_ext_addr,
   input wire logic [7:0] o_ext_wdata,
   input wire logic o_ext_wr,
   input wire logic o_ext_rd,
   input wire logic [7:0] i_ext_rdata,
   input wire logic o_mcycle_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   logic ram_acc;
   assign ram_acc = (i_bus_rd | i_bus_wr) & (i_bus_addr <= crm_pkg::RAM_LAST) & i_ram_enable
      & ~i_standby;
   // Vector high byte read, then the next byte one machine cycle later
   sequence vec_pair;
      o_ext_rd ##4 (o_ext_rd && o_ext_addr == $past(o_ext_addr, 4) + 16'h0001);
   endsequence
   sequence push_run;
      o_ext_wr ##24 o_ext_wr;
   endsequence
   ram_hit_a: assert property (ram_acc |=> o_ram_hit) else $error("no RAM hit");
   no_hit_a: assert property (!ram_acc |=> !o_ram_hit) else $error("stray RAM hit");
   ram_drive_a: assert property (i_bus_rd && ram_acc |=> o_bus_data_oe)
      else $error("RAM read not driven");
   ccr_ones_a: assert property (i_reg_rd && i_reg_addr == crm_pkg::REG_CCR
      |=> o_reg_rdata[7:6] == 2'b11) else $error("flag top bits");
   mcycle_gap_a: assert property (o_mcycle_en |=> !o_mcycle_en [*3] ##1 o_mcycle_en)
      else $error("machine cycle spacing");
   push_down_a: assert property (o_ext_wr && $past(o_ext_wr, 4)
      |-> o_ext_addr == $past(o_ext_addr, 4) - 16'h0001) else $error("stack order");
   service_seq_a: assert property (o_ext_wr && !$past(o_ext_wr, 4)
      |-> push_run ##4 vec_pair) else $error("service sequence");
   vec_addr_a: assert property (o_ext_rd |-> o_ext_addr[15:3] == 13'h1fff
      && o_ext_addr[2:1] != 2'b01) else $error("bad vector address");
   restart_a: assert property ($fell(i_srst) |-> ##[1:12]
      (o_ext_rd && o_ext_addr == crm_pkg::VEC_RESTART)) else $error("no restart fetch");
   rdata_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
      else $error("read data not cleared");
endmodule : crm_checker
bind crm_top crm_checker i_crm_checker (.*);
`default_nettype wire

// ===== dv/crm_ext_mem.sv
// Purpose: External memory answering stack pushes and vector reads
// Assumes: Read data taken at the edge that ends the read pulse
// Notes: Vector byte is the inverted low address byte
`timescale 1ns/10ps
`default_nettype none
module crm_ext_mem (
   // Clock
   input wire logic i_clk,
   // Master side
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   // Answer
   output logic [7:0] o_rdata
);
   logic [7:0] stk [16];
   logic [7:0] stale = 8'h5a;
   // Answer stands within the read pulse; outside it the data toggles
   // Vector bytes never point into internal RAM, so no fetch runs there
   assign o_rdata = i_rd ? ~i_addr[7:0] : stale;
   always @(posedge i_clk) begin
      stale <= ~stale;
      if (i_wr) begin
         stk[i_addr[3:0]] <= i_wdata;
      end
   end
endmodule : crm_ext_mem
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for crm_top
// Assumes: 50 MHz clock, reset held 4 cycles
// Notes: Vectors give PC 0100, 0706, 0302
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} crm_row_t;
   logic i_clk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_bus_wr = 1'b0;
   logic i_bus_rd = 1'b0, i_ram_enable = 1'b1, i_standby = 1'b0, i_irq_req = 1'b0;
   logic i_nmi_req = 1'b0, i_pc_step = 1'b0, o_bus_data_oe, o_ram_hit, o_ext_wr, o_ext_rd;
   logic o_mcycle_en;
   logic [3:0] i_reg_addr = 4'h0;
   logic [15:0] i_reg_wdata = 16'h0000, i_bus_addr = 16'h0000, o_reg_rdata, o_ext_addr, got;
   logic [7:0] i_bus_wdata = 8'h00, o_bus_rdata, o_ext_wdata, i_ext_rdata;
   int mismatches = 0;
   int check_count = 0;
   crm_row_t rows [9] = '{'{4'h0, 16'h1234, 16'h1234}, '{4'h1, 16'h000f, 16'h000f},
      '{4'h2, 16'habcd, 16'habcd}, '{4'h3, 16'h007f, 16'h007f}, '{4'h4, 16'h0001, 16'h0001},
      '{4'h5, 16'h0000, 16'h00c0}, '{4'h5, 16'h003f, 16'h00ff}, '{4'h8, 16'h1111, 16'h0000},
      '{4'h6, 16'h00ff, 16'h0008}};
   logic [7:0] stack_exp [6] = '{8'h34, 8'h12, 8'hcd, 8'hab, 8'hff, 8'h01};
   always #10 i_clk = ~i_clk;
   crm_top i_crm_top (.i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
      .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata),
      .o_bus_data_oe(o_bus_data_oe), .o_ram_hit(o_ram_hit), .i_ram_enable(i_ram_enable),
      .i_standby(i_standby), .i_irq_req(i_irq_req), .i_nmi_req(i_nmi_req),
      .i_pc_step(i_pc_step), .o_ext_addr(o_ext_addr), .o_ext_wdata(o_ext_wdata),
      .o_ext_wr(o_ext_wr), .o_ext_rd(o_ext_rd), .i_ext_rdata(i_ext_rdata),
      .o_mcycle_en(o_mcycle_en));
   crm_ext_mem i_crm_ext_mem (.i_clk(i_clk), .i_addr(o_ext_addr), .i_wdata(o_ext_wdata),
      .i_wr(o_ext_wr), .i_rd(o_ext_rd), .o_rdata(i_ext_rdata));
   task automatic report_and_stop;
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 got = o_reg_rdata;
   endtask : rd
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_bus_addr <= a;
      i_bus_wdata <= d;
      i_bus_wr <= w;
      i_bus_rd <= ~w;
      @(posedge i_clk);
      i_bus_wr <= 1'b0;
      i_bus_rd <= 1'b0;
      #1 got = {6'h00, o_bus_data_oe, o_ram_hit, o_bus_rdata};
   endtask : bus
   task automatic wait_idle;
      repeat (8) @(posedge i_clk);
      got = 16'h0001;
      for (int n = 0; n < 200 && got[0] !== 1'b0; n++) rd(crm_pkg::REG_STATUS);
      chk({15'h0000, got[0]}, 16'h0000);
   endtask : wait_idle
   task automatic do_reset;
      i_srst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      wait_idle();
      rd(crm_pkg::REG_PC);
      chk(got, 16'h0100);
      rd(crm_pkg::REG_CCR);
      chk(got, 16'h00d0);
   endtask : do_reset
   initial begin
      do_reset();
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a);
         chk(got, rows[k].e);
      end
      wr(crm_pkg::REG_ALU_OP, 16'h0000);
      rd(crm_pkg::REG_CCR);
      chk(got, 16'h00fa);
      wr(crm_pkg::REG_ALU_OP, 16'h0002);
      rd(crm_pkg::REG_CCR);
      chk(got, 16'h00f4);
      wr(crm_pkg::REG_ALU_OP, 16'h0003);
      rd(crm_pkg::REG_CCR);
      chk(got, 16'h00f0);
      wr(crm_pkg::REG_ALU_OP, 16'h0001);
      rd(crm_pkg::REG_ACCA);
      chk(got, 16'h0000);
      wr(crm_pkg::REG_ALU_OP, 16'h0001);
      rd(crm_pkg::REG_CCR);
      chk(got, 16'h00f9);
      @(posedge i_clk);
      i_irq_req <= 1'b1;
      repeat (40) @(posedge i_clk);
      rd(crm_pkg::REG_STATUS);
      chk(got, 16'h0008);
      wr(crm_pkg::REG_CCR, 16'h0000);
      wait_idle();
      rd(crm_pkg::REG_PC);
      chk(got, 16'h0706);
      rd(crm_pkg::REG_SP);
      chk(got, 16'h0008);
      rd(crm_pkg::REG_CCR);
      chk(got, 16'h00d0);
      for (int k = 0; k < 6; k++) begin
         chk({8'h00, i_crm_ext_mem.stk[15 - k]}, {8'h00, stack_exp[k]});
      end
      @(posedge i_clk);
      i_nmi_req <= 1'b1;
      @(posedge i_clk);
      i_nmi_req <= 1'b0;
      wait_idle();
      rd(crm_pkg::REG_PC);
      chk(got, 16'h0302);
      wr(crm_pkg::REG_PC, 16'hffff);
      i_pc_step <= 1'b1;
      @(posedge i_clk);
      i_pc_step <= 1'b0;
      rd(crm_pkg::REG_PC);
      chk(got, 16'h0000);
      bus(1'b1, 16'h0005, 8'ha5);
      bus(1'b1, 16'h0040, 8'h3c);
      bus(1'b0, 16'h0040, 8'h00);
      chk(got, 16'h033c);
      bus(1'b0, 16'h0080, 8'h00);
      chk(got & 16'h0300, 16'h0000);
      i_ram_enable <= 1'b0;
      i_standby <= 1'b1;
      bus(1'b1, 16'h0005, 8'hff);
      chk(got & 16'h0300, 16'h0000);
      rd(crm_pkg::REG_STATUS);
      chk(got, 16'h0004);
      i_standby <= 1'b0;
      i_ram_enable <= 1'b1;
      bus(1'b0, 16'h0040, 8'h00);
      chk(got, 16'h0300);
      i_ram_enable <= 1'b0;
      bus(1'b0, 16'h0005, 8'h00);
      chk(got & 16'h0300, 16'h0000);
      i_ram_enable <= 1'b1;
      do_reset();
      bus(1'b0, 16'h0005, 8'h00);
      chk(got, 16'h03a5);
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      mismatches++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
